// ---- pmid_regs.svh ----
// register codes, field positions, fixed values and timing for the identity/scratch bank
`ifndef PMID_REGS_SVH
`define PMID_REGS_SVH

// ==========================================================================
// command codes
`define PMID_CMD_PROTO_FLAGS    8'h19
`define PMID_CMD_PROTO_REV      8'h98
`define PMID_CMD_TOOL_A         8'hb0
`define PMID_CMD_TOOL_PAGED     8'hb1
`define PMID_CMD_OEM            8'hb2
`define PMID_CMD_SCRATCH_PAGED  8'hb3
`define PMID_CMD_SCRATCH_SHARED 8'hb4
`define PMID_CMD_INFO           8'hb6
`define PMID_CMD_VENDOR_RSV     8'hbc
`define PMID_CMD_MAKER_ID       8'he7
`define PMID_CMD_LOT            8'he8

// ==========================================================================
// fixed field values of the protocol-support byte
`define PMID_CAP_PEC_BIT        7
`define PMID_CAP_SCL_LSB        5
`define PMID_CAP_SCL_400K       2'h1
`define PMID_CAP_ALERT_BIT      4
`define PMID_PROTO_FLAGS_VAL    8'hb0
`define PMID_PROTO_REV_VAL      8'h11

// ==========================================================================
// information word and scratch reset values
`define PMID_INFO_ECC_BIT       5
`define PMID_SCRATCH_RESET      16'h0000
// arbitrary neutral identity value, not any real maker code
`define PMID_MAKER_ID_VAL       16'h5a5a

// ==========================================================================
// timing: cycles for an answer, one clock at 40 MHz
`define PMID_READ_LATENCY       1

`endif

// ---- pmid_pkg.sv ----
// types shared by the identity/scratch register bank
package pmid_pkg;

  // command port request from the bus protocol engine
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] code;
    logic [15:0] wdata;
    logic       page;
  } pmid_req_s;

  // answer back to the protocol engine
  typedef struct packed {
    logic        valid;
    logic        hit;
    logic [15:0] rdata;
  } pmid_rsp_s;

  // non-volatile image port (eeprom controller side)
  typedef struct packed {
    logic        load;
    logic        ecc_ok;
    logic [15:0] tool_a;
    logic [15:0] tool_p0;
    logic [15:0] tool_p1;
    logic [15:0] oem;
    logic [15:0] scr_p0;
    logic [15:0] scr_p1;
    logic [15:0] scr_sh;
    logic [7:0]  lot0;
    logic [7:0]  lot1;
  } pmid_nvm_s;

endpackage

// ---- pmid_page_word.sv ----
// one paged 16-bit word: a copy per channel, selected by the page
`timescale 1ns/1ps
`default_nettype none

`include "pmid_regs.svh"

module pmid_page_word
  import pmid_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // access
  input  wire logic        wr,
  input  wire logic        page,
  input  wire logic [15:0] wdata,
  // bulk load from non-volatile image
  input  wire logic        load,
  input  wire logic [15:0] load_p0,
  input  wire logic [15:0] load_p1,
  // selected copy
  output logic      [15:0] rdata
);

  typedef struct packed {
    logic [15:0] ch0;
    logic [15:0] ch1;
  } pmid_pw_s;

  pmid_pw_s st_reg;
  pmid_pw_s st_next;

  // next state: a bulk load wins over a host write in the same cycle
  always_comb begin
    st_next = st_reg;
    if (load) begin
      st_next.ch0 = load_p0;
      st_next.ch1 = load_p1;
    end else if (wr) begin
      if (page) st_next.ch1 = wdata;
      else      st_next.ch0 = wdata;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_reg <= '{ch0: `PMID_SCRATCH_RESET, ch1: `PMID_SCRATCH_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = page ? st_reg.ch1 : st_reg.ch0;

endmodule
`default_nettype wire

// ---- pmid_bank.sv ----
// identification, information and scratchpad register bank of the supply manager
`timescale 1ns/1ps
`default_nettype none

`include "pmid_regs.svh"

module pmid_bank
  import pmid_pkg::*;
(
  // clock and reset
  input  wire logic      clock,
  input  wire logic      nrst,
  // command port from the protocol engine
  input  wire pmid_req_s req,
  output pmid_rsp_s      rsp,
  // non-volatile image and restore strobe
  input  wire pmid_nvm_s nvm,
  input  wire logic      restore_all
);

  // ========================================================================
  // state
  typedef struct packed {
    logic [15:0] tool_a;
    logic [15:0] oem;
    logic [15:0] scr_sh;
    logic [15:0] vnd0;
    logic [15:0] vnd1;
    logic [7:0]  lot0;
    logic [7:0]  lot1;
    logic        ecc_ok;
    logic        info_stale;
    pmid_rsp_s   rsp;
  } pmid_st_s;

  pmid_st_s st_reg;
  pmid_st_s st_next;

  logic [15:0] tool_p_rd;
  logic [15:0] scr_p_rd;
  logic        load_any;

  // ========================================================================
  // helpers
  function automatic logic is_code(input logic [7:0] c, input logic [7:0] k);
    is_code = (c == k);
  endfunction

  // constant capability byte built from its fields
  function automatic logic [7:0] cap_byte();
    logic [7:0] b;
    b = 8'h00;
    b[`PMID_CAP_PEC_BIT] = 1'b1;
    b[`PMID_CAP_SCL_LSB +: 2] = `PMID_CAP_SCL_400K;
    b[`PMID_CAP_ALERT_BIT] = 1'b1;
    cap_byte = b;
  endfunction

  // bulk read of the eeprom image also counts as a restore
  assign load_any = nvm.load | restore_all;

  // ========================================================================
  // paged eeprom-backed words
  pmid_page_word u_tool_paged (
    .clock   (clock),
    .nrst    (nrst),
    .wr      (req.wr && is_code(req.code, `PMID_CMD_TOOL_PAGED)),
    .page    (req.page),
    .wdata   (req.wdata),
    .load    (load_any),
    .load_p0 (nvm.tool_p0),
    .load_p1 (nvm.tool_p1),
    .rdata   (tool_p_rd)
  );

  pmid_page_word u_scratch_paged (
    .clock   (clock),
    .nrst    (nrst),
    .wr      (req.wr && is_code(req.code, `PMID_CMD_SCRATCH_PAGED)),
    .page    (req.page),
    .wdata   (req.wdata),
    .load    (load_any),
    .load_p0 (nvm.scr_p0),
    .load_p1 (nvm.scr_p1),
    .rdata   (scr_p_rd)
  );

  // ========================================================================
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.rsp = '0;
    // image load: refreshes backed words, lot bytes and info word
    if (load_any) begin
      st_next.tool_a     = nvm.tool_a;
      st_next.oem        = nvm.oem;
      st_next.scr_sh     = nvm.scr_sh;
      st_next.lot0       = nvm.lot0;
      st_next.lot1       = nvm.lot1;
      st_next.ecc_ok     = nvm.ecc_ok;
      st_next.info_stale = 1'b0;
    end else if (st_reg.info_stale) begin
      // first cycle after power-on: take the image status
      st_next.ecc_ok     = nvm.ecc_ok;
      st_next.lot0       = nvm.lot0;
      st_next.lot1       = nvm.lot1;
      st_next.info_stale = 1'b0;
    end else if (req.wr) begin
      // read-only codes ignore writes; load beats a same-cycle write
      case (req.code)
        `PMID_CMD_TOOL_A:         st_next.tool_a = req.wdata;
        `PMID_CMD_OEM:            st_next.oem    = req.wdata;
        `PMID_CMD_SCRATCH_SHARED: st_next.scr_sh = req.wdata;
        `PMID_CMD_VENDOR_RSV: begin
          if (req.page) st_next.vnd1 = req.wdata;
          else          st_next.vnd0 = req.wdata;
        end
        default: ;
      endcase
    end
    // read answer, one cycle after the request
    if (req.rd) begin
      st_next.rsp.valid = 1'b1;
      st_next.rsp.hit   = 1'b1;
      case (req.code)
        `PMID_CMD_PROTO_FLAGS:    st_next.rsp.rdata = {8'h00, cap_byte()};
        `PMID_CMD_PROTO_REV:      st_next.rsp.rdata = {8'h00, `PMID_PROTO_REV_VAL};
        `PMID_CMD_MAKER_ID:       st_next.rsp.rdata = `PMID_MAKER_ID_VAL;
        `PMID_CMD_LOT:            st_next.rsp.rdata =
                                    {8'h00, req.page ? st_reg.lot1 : st_reg.lot0};
        `PMID_CMD_INFO: begin
          st_next.rsp.rdata = 16'h0000;
          st_next.rsp.rdata[`PMID_INFO_ECC_BIT] = st_reg.ecc_ok;
        end
        `PMID_CMD_TOOL_A:         st_next.rsp.rdata = st_reg.tool_a;
        `PMID_CMD_TOOL_PAGED:     st_next.rsp.rdata = tool_p_rd;
        `PMID_CMD_OEM:            st_next.rsp.rdata = st_reg.oem;
        `PMID_CMD_SCRATCH_PAGED:  st_next.rsp.rdata = scr_p_rd;
        `PMID_CMD_SCRATCH_SHARED: st_next.rsp.rdata = st_reg.scr_sh;
        `PMID_CMD_VENDOR_RSV:     st_next.rsp.rdata =
                                    req.page ? st_reg.vnd1 : st_reg.vnd0;
        default: begin
          // unknown code: answer with a miss so the engine can nack
          st_next.rsp.hit   = 1'b0;
          st_next.rsp.rdata = 16'h0000;
        end
      endcase
    end
  end

  // ========================================================================
  // state register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_reg            <= '0;
      st_reg.scr_sh     <= `PMID_SCRATCH_RESET;
      st_reg.ecc_ok     <= 1'b1;
      st_reg.info_stale <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rsp = st_reg.rsp;

endmodule
`default_nettype wire

// ---- pmid_bank_properties.sv ----
// checker for the identity and scratch register bank
`timescale 1ns/1ps
`default_nettype none
`include "pmid_regs.svh"
module pmid_bank_properties
  import pmid_pkg::*;
(
  // clock and reset
  input wire logic      clock,
  input wire logic      nrst,
  // watched ports
  input wire pmid_req_s req,
  input wire pmid_rsp_s rsp,
  input wire pmid_nvm_s nvm,
  input wire logic      restore_all
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // fixed answers, one cycle after the read
  a_flags_fixed: assert property (req.rd && req.code == 8'h19
    |=> rsp.valid && rsp.hit && rsp.rdata == 16'h00b0) else $error("flags byte wrong");
  a_rev_fixed: assert property (req.rd && req.code == 8'h98
    |=> rsp.valid && rsp.rdata == 16'h0011) else $error("revision byte wrong");
  a_maker_fixed: assert property (req.rd && req.code == 8'he7
    |=> rsp.rdata == `PMID_MAKER_ID_VAL) else $error("maker word wrong");
  a_lot_byte: assert property (req.rd && req.code == 8'he8
    |=> rsp.hit && rsp.rdata[15:8] == 8'h00) else $error("lot byte upper bits");
  a_info_bits: assert property (req.rd && req.code == 8'hb6
    |=> rsp.rdata[15:6] == 10'h0 && rsp.rdata[4:0] == 5'h0) else $error("info reserved");
  // info refresh follows ecc status taken with the load strobe
  a_info_follow: assert property ((nvm.load || restore_all) ##2
    (req.rd && req.code == 8'hb6) |=> rsp.rdata[5] == $past(nvm.ecc_ok, 3))
    else $error("info ecc bit stale");
  // write, idle, read of the same copy returns the written word
  a_word_back: assert property ((nrst && $past(nrst) && req.wr && !nvm.load && !restore_all
    && req.code inside {8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hbc})
    ##1 (!req.wr && !nvm.load && !restore_all) ##1 (req.rd && req.code == $past(req.code, 2)
    && req.page == $past(req.page, 2)) |=> rsp.rdata == $past(req.wdata, 3))
    else $error("word readback wrong");
  a_unknown_code: assert property (req.rd && req.code == 8'h00 // unknown codes answer valid with a miss
    |=> rsp.valid && !rsp.hit && rsp.rdata == 16'h0) else $error("unknown code answered");
  c_load_info: cover property (nvm.load ##2 (req.rd && req.code == 8'hb6));
  c_restore: cover property (restore_all ##2 req.rd);
  c_paged_rd: cover property (req.rd && req.page && req.code == 8'hb3);
endmodule
`default_nettype wire

// ---- pmid_host.sv ----
// host command model: one request per call, answer taken a cycle later
`timescale 1ns/1ps
`default_nettype none
module pmid_host
  import pmid_pkg::*;
(
  // clock
  input wire logic      clock,
  // command port
  output var pmid_req_s req,
  input wire pmid_rsp_s rsp
);
  initial req = '0;
  // strobes drop after one cycle; idle code 0 never repeats a held request
  task automatic op(input logic rd, input logic wr, input logic [7:0] code,
                    input logic page, input logic [15:0] wd, output pmid_rsp_s got);
    @(negedge clock);
    req = '{rd: rd, wr: wr, code: code, wdata: wd, page: page};
    @(negedge clock);
    got = rsp;
    req = '0;
  endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the identity and scratch register bank
`timescale 1ns/1ps
`default_nettype none
`include "pmid_regs.svh"
module testbench;
  import pmid_pkg::*;
  logic      clock = 1'b0;
  logic      nrst = 1'b0;
  logic      restore_all = 1'b0;
  pmid_req_s req;
  pmid_rsp_s rsp;
  pmid_nvm_s nvm;
  pmid_rsp_s got;
  int        errors = 0;
  int        n_checks = 0;
  logic [7:0] codes [6] = '{8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hbc};
  logic       paged [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  always #12.5 clock = ~clock;
  pmid_bank i_dut (.clock(clock), .nrst(nrst), .req(req), .rsp(rsp), .nvm(nvm),
                   .restore_all(restore_all));
  pmid_host i_host (.clock(clock), .req(req), .rsp(rsp));
  // ==========================================================
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // answer compared whole: valid, hit and data
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] seen);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rdc(input logic [7:0] code, input logic page, input logic [15:0] exp);
    i_host.op(1'b1, 1'b0, code, page, 16'h0, got);
    chk($sformatf("code %h page %0d", code, page), {2'b11, exp}, got);
  endtask
  task automatic wrc(input logic [7:0] code, input logic page, input logic [15:0] wd);
    i_host.op(1'b0, 1'b1, code, page, wd, got);
  endtask
  // ==========================================================
  // flags byte survives a write, fixed values read back; unknown codes miss
  task automatic t_fixed;
    wrc(8'h19, 1'b0, 16'h00ff);
    rdc(8'h19, 1'b0, 16'h00b0);
    rdc(8'h98, 1'b1, 16'h0011);
    rdc(8'he7, 1'b0, `PMID_MAKER_ID_VAL);
    i_host.op(1'b1, 1'b0, 8'h00, 1'b0, 16'h0, got);
    chk("unknown code", 18'h20000, got);
  endtask
  // per-page copies kept apart; unpaged words shared by both pages
  task automatic t_paged;
    rdc(8'hb3, 1'b1, 16'h0000);
    rdc(8'hb4, 1'b0, 16'h0000);
    foreach (codes[i]) begin
      wrc(codes[i], 1'b0, {8'h10, codes[i]});
      wrc(codes[i], 1'b1, {8'h20, codes[i]});
      // page 1 read first: write, idle, read of one copy wakes the readback check
      rdc(codes[i], 1'b1, {8'h20, codes[i]});
      rdc(codes[i], 1'b0, {paged[i] ? 8'h10 : 8'h20, codes[i]});
    end
  endtask
  // lot bytes, info refresh on load and restore, image reload
  task automatic t_image;
    rdc(8'he8, 1'b0, 16'h003c);
    rdc(8'he8, 1'b1, 16'h00c3);
    rdc(8'hb6, 1'b0, 16'h0020);
    @(negedge clock);
    nvm.ecc_ok = 1'b0;
    nvm.load = 1'b1;
    @(negedge clock);
    nvm.load = 1'b0;
    rdc(8'hb6, 1'b0, 16'h0000);
    rdc(8'hb4, 1'b0, 16'h4b4b);
    rdc(8'hb3, 1'b1, 16'h3b31);
    @(negedge clock);
    nvm.ecc_ok = 1'b1;
    restore_all = 1'b1;
    @(negedge clock);
    restore_all = 1'b0;
    rdc(8'hb6, 1'b1, 16'h0020);
  endtask
  initial begin
    nvm = '{load: 1'b0, ecc_ok: 1'b1, scr_p1: 16'h3b31, scr_sh: 16'h4b4b,
            lot0: 8'h3c, lot1: 8'hc3, default: '0};
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    repeat (2) @(negedge clock);
    t_fixed;
    t_paged;
    t_image;
    print_verdict;
  end
  // run needs about 90 cycles; hang cut well beyond
  initial begin
    repeat (2000) @(posedge clock);
    errors++;
    print_verdict;
  end
endmodule
bind pmid_bank pmid_bank_properties i_props (.clock(clock), .nrst(nrst), .req(req),
  .rsp(rsp), .nvm(nvm), .restore_all(restore_all));
`default_nettype wire
